// file: core/das_instruction_sequencer.sv
// Instruction sequencer, timer, result FIFO and AHB-Lite register slave of the acquisition system
`timescale 1ns/10ps

//
// Contract
// - Instructions run in ascending order, back to back unless a timer delay is requested.
// - After an instruction with its loop bit set, execution returns to instruction zero.
// - An instruction with its timer bit set first waits out the timer delay.
// - Interrupt is raised once the FIFO holds the programmed threshold of results.
// - The host may read the FIFO while the sequencer keeps converting.
// - The conversion clock pauses during each host register access.
// - Top four instruction bits set the acquisition time extension.
// - Bit 9 enables the timer; zero negative field means single-ended; zero positive is input zero.
// - Bits 7 to 5 select the negative input; differential results are signed.
// - Bit 10 selects 8-bit conversion; bits 4 to 2 select the positive input.
// - Bit 11 selects limit-compare mode instead of producing a result.
// - One limit-compare instruction checks both its high and its low limit.
// - Bit 0 of an instruction is the loop bit marking the last instruction.
// - Configuration write with bit 0 set starts the sequencer.
// - Configuration write with bit 1 set resets the device logic.
// - Configuration write with bit 3 set starts a full self-calibration.
// - Configuration bits 9 and 8 select the RAM bank; bank 1 holds limits, stopped.
// - Configuration write of all zeros stops the sequencer.
// - When enabled, the instruction number is placed in result bits 15 to 13.
// - Two single-clock states, then 44 clocks (12-bit) or 21 clocks (8-bit) conversion; the code runs the acquisition state in between.
// - Limit compare uses 5, then 1, then 5 clocks after acquisition.
// - Each timer count is 32 converter clocks.
// - The timer delay adds a fixed 2 clocks to the programmed count.
module das_instruction_sequencer
  import das_seq_pkg::*;
(
  input  wire logic                    core_clk,   // Converter clock, 200 MHz
  input  wire logic                    arst_n,     // Asynchronous reset, active low
  input  wire logic                    hsel,       // AHB slave select
  input  wire logic [31:0]             haddr,      // AHB address
  input  wire logic [1:0]              htrans,     // AHB transfer type
  input  wire logic                    hwrite,     // AHB write
  input  wire logic [2:0]              hsize,      // AHB size
  input  wire logic [31:0]             hwdata,     // AHB write data
  input  wire logic                    hready,     // AHB bus ready
  output logic                         hreadyout,  // AHB slave ready
  output logic [31:0]                  hrdata,     // AHB read data
  output logic                         hresp,      // AHB response, always OKAY
  input  wire logic [12:0]             convData,   // Converter result, sign plus 12 bits
  output das_seq_pkg::afe_ctrl_t       afeCtrl,    // Front-end control
  output logic                         resultIrq   // Result threshold interrupt
);
  import das_seq_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes take no wait state, reads one

  logic       dpValid_q;
  logic       dpWrite_q;
  logic       dpWord_q;
  logic       rdWait_q;
  logic [7:0] dpAddr_q;
  logic [31:0] hrdata_q;

  wire addrPhase = hsel && htrans[1] && hready;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dpValid_q <= 1'b0;
      dpWrite_q <= 1'b0;
      dpWord_q  <= 1'b0;
      rdWait_q  <= 1'b0;
      dpAddr_q  <= 8'h00;
    end else begin
      rdWait_q <= addrPhase && !hwrite;
      if (addrPhase) begin
        dpValid_q <= 1'b1;
        dpWrite_q <= hwrite;
        dpWord_q  <= (hsize == HSIZE_WORD);
        dpAddr_q  <= haddr[7:0];
      end else if (hreadyout) begin
        dpValid_q <= 1'b0;
      end
    end
  end

  // Reads stall a cycle because the read data is registered into hrdata_q before it reaches hrdata
  assign hreadyout = !(dpValid_q && rdWait_q);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  wire wrStrobe  = dpValid_q && dpWrite_q && dpWord_q;
  wire rdStrobe  = dpValid_q && rdWait_q;
  wire selInstr  = (dpAddr_q < OFS_CONFIG) && (dpAddr_q[1:0] == 2'b00);
  wire selConfig = (dpAddr_q == OFS_CONFIG);
  wire selTimer  = (dpAddr_q == OFS_TIMER);
  wire selFifo   = (dpAddr_q == OFS_FIFO);
  wire selStatus = (dpAddr_q == OFS_STATUS);
  wire selCtrl   = (dpAddr_q == OFS_CONTROL);
  wire selLimit  = (dpAddr_q == OFS_LIMIT);
  wire [2:0] wordIdx = dpAddr_q[4:2];

  // Conversion clock enable, held off while any access is in its data phase
  wire convTick = !dpValid_q;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0] ram_q [RAM_BANKS][INSTR_WORDS];
  logic [1:0]  ramPtr_q;
  logic        running_q;
  logic        calPending_q;
  logic [15:0] timerPreset_q;
  logic [15:0] control_q;

  wire cfgWrite  = wrStrobe && selConfig;
  wire softReset = cfgWrite && hwdata[CFG_RESET];

  genvar gb;
  genvar gw;
  generate
    for (gb = 0; gb < RAM_BANKS; gb++) begin : gBank
      for (gw = 0; gw < INSTR_WORDS; gw++) begin : gWord
        wire hit = wrStrobe && selInstr && (ramPtr_q == 2'(gb)) && (wordIdx == 3'(gw));
        always_ff @(posedge core_clk or negedge arst_n) begin
          if (!arst_n) begin
            ram_q[gb][gw] <= 16'h0000;
          end else if (hit) begin
            ram_q[gb][gw] <= hwdata[15:0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ramPtr_q      <= BANK_INSTR;
      running_q     <= 1'b0;
      timerPreset_q <= RST_TIMER;
      control_q     <= RST_CONTROL;
    end else begin
      if (cfgWrite) begin
        ramPtr_q  <= hwdata[CFG_RPTR_HI:CFG_RPTR_LO];
        // Any configuration write without the start bit leaves the sequencer stopped
        running_q <= hwdata[CFG_START] && !hwdata[CFG_RESET];
      end
      if (wrStrobe && selTimer) begin
        timerPreset_q <= hwdata[15:0];
      end
      if (wrStrobe && selCtrl) begin
        control_q <= hwdata[15:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  seq_state_t       state_q;
  seq_state_t       nextState;
  logic [2:0]       instrPtr_q;
  logic [CNT_W-1:0] cnt_q;

  wire instr_t cur     = instr_t'(ram_q[BANK_INSTR][instrPtr_q]);
  wire         stepNow = convTick && (cnt_q == '0);
  wire         instrEnd = stepNow && ((state_q == S_CONV) || (state_q == S_CMPC));
  wire [2:0]   ptrNext  = cur.loop ? 3'h0 : 3'(instrPtr_q + 3'h1);

  // Length of a state, counted in enabled converter clocks
  function automatic logic [CNT_W-1:0] stateLen(input seq_state_t st, input instr_t ins,
                                                 input logic [15:0] preset);
    logic [CNT_W-1:0] acqBase;
    acqBase = ins.res8 ? LEN_ACQ8 : LEN_ACQ12;
    case (st)
      S_TIMER: stateLen = CNT_W'({preset, 5'b0}) + LEN_TMR_FIXED;
      S_ACQ:   stateLen = acqBase + CNT_W'({ins.acqTime, 1'b0});
      S_CONV:  stateLen = ins.res8 ? LEN_CONV8 : LEN_CONV12;
      S_CMPA:  stateLen = LEN_CMP_LONG;
      S_CMPB:  stateLen = LEN_CMP_SHORT;
      S_CMPC:  stateLen = LEN_CMP_LONG;
      S_CAL:   stateLen = LEN_CAL;
      default: stateLen = LEN_SINGLE;
    endcase
  endfunction

  always_comb begin
    nextState = state_q;
    case (state_q)
      S_IDLE: begin
        if (calPending_q) begin
          nextState = S_CAL;
        end else if (running_q) begin
          nextState = S_FETCH;
        end
      end
      S_FETCH:  nextState = S_DECODE;
      S_DECODE: nextState = cur.timerEn ? S_TIMER : S_ACQ;
      S_TIMER:  nextState = S_ACQ;
      S_ACQ:    nextState = cur.wdog ? S_CMPA : S_CONV;
      S_CONV:   nextState = running_q ? S_FETCH : S_IDLE;
      S_CMPA:   nextState = S_CMPB;
      S_CMPB:   nextState = S_CMPC;
      S_CMPC:   nextState = running_q ? S_FETCH : S_IDLE;
      S_CAL:    nextState = S_IDLE;
      default:  nextState = S_IDLE;
    endcase
  end

  // A stop aborts the instruction in progress; one ending in the first cycle after the stop still delivers its result
  wire abortRun = !running_q && (state_q != S_IDLE) && (state_q != S_CAL);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= S_IDLE;
      instrPtr_q <= 3'h0;
      cnt_q      <= '0;
    end else if (softReset || abortRun) begin
      state_q    <= S_IDLE;
      instrPtr_q <= 3'h0;
      cnt_q      <= '0;
    end else if (stepNow && (nextState != state_q)) begin
      state_q <= nextState;
      cnt_q   <= stateLen(nextState, cur, timerPreset_q) - LEN_SINGLE;
      if (instrEnd) begin
        instrPtr_q <= ptrNext;
      end
    end else if (convTick && (cnt_q != '0)) begin
      cnt_q <= cnt_q - LEN_SINGLE;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      calPending_q <= 1'b0;
    end else if (cfgWrite && hwdata[CFG_FULLCAL]) begin
      calPending_q <= 1'b1;
    end else if (state_q == S_CAL) begin
      calPending_q <= 1'b0;
    end
  end

  assign afeCtrl.posSel      = cur.posSel;
  assign afeCtrl.negSel      = cur.negSel;
  assign afeCtrl.singleEnded = (cur.negSel == NEG_GROUND);
  assign afeCtrl.res8        = cur.res8;
  assign afeCtrl.acquire     = (state_q == S_ACQ);
  assign afeCtrl.convert     = (state_q == S_CONV);
  assign afeCtrl.compare     = (state_q == S_CMPA) || (state_q == S_CMPB) || (state_q == S_CMPC);
  assign afeCtrl.calibrate   = (state_q == S_CAL);

  //////////////////////////////////////////////////////////////////////////////////////////
  // Limit compare against both limits of the instruction

  wire signed [15:0] sample  = {{3{convData[12]}}, convData};
  wire signed [15:0] limHigh = {{3{ram_q[BANK_HIGH][instrPtr_q][12]}},
                                ram_q[BANK_HIGH][instrPtr_q][12:0]};
  wire signed [15:0] limLow  = {{3{ram_q[BANK_LOW][instrPtr_q][12]}},
                                ram_q[BANK_LOW][instrPtr_q][12:0]};
  wire cmpDone  = stepNow && (state_q == S_CMPC);
  wire overHigh = cmpDone && (sample > limHigh);
  wire underLow = cmpDone && (sample < limLow);
  wire limRead  = rdStrobe && selLimit;

  logic [7:0] highFlags_q;
  logic [7:0] lowFlags_q;

  // A limit event in the cycle of the clearing read survives it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      highFlags_q <= 8'h00;
      lowFlags_q  <= 8'h00;
    end else if (softReset) begin
      highFlags_q <= 8'h00;
      lowFlags_q  <= 8'h00;
    end else begin
      highFlags_q <= (limRead ? 8'h00 : highFlags_q) | (overHigh ? 8'(1) << instrPtr_q : 8'h00);
      lowFlags_q  <= (limRead ? 8'h00 : lowFlags_q) | (underLow ? 8'(1) << instrPtr_q : 8'h00);
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Result FIFO, read by the host while conversions go on

  logic [15:0] fifoMem [FIFO_DEPTH];
  logic [4:0]  wrPtr_q;
  logic [4:0]  rdPtr_q;
  logic [5:0]  fifoCount_q;
  logic        overflow_q;
  logic        irq_q;

  wire        convDone  = stepNow && (state_q == S_CONV);
  wire        fifoFull  = (fifoCount_q == 6'(FIFO_DEPTH));
  wire        fifoEmpty = (fifoCount_q == 6'h00);
  wire        push      = convDone && !fifoFull;
  wire        pop       = rdStrobe && selFifo && !fifoEmpty;
  wire [2:0]  tagBits   = control_q[CTL_TAG] ? instrPtr_q : 3'h0;
  wire [15:0] resultWord = {tagBits, convData};
  wire [5:0]  threshold = control_q[CTL_THR_HI:CTL_THR_LO];

  always_ff @(posedge core_clk) begin
    if (push) begin
      fifoMem[wrPtr_q] <= resultWord;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_q     <= 5'h00;
      rdPtr_q     <= 5'h00;
      fifoCount_q <= 6'h00;
      overflow_q  <= 1'b0;
      irq_q       <= 1'b0;
    end else if (softReset) begin
      wrPtr_q     <= 5'h00;
      rdPtr_q     <= 5'h00;
      fifoCount_q <= 6'h00;
      overflow_q  <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 5'h01;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 5'h01;
      end
      if (push && !pop) begin
        fifoCount_q <= fifoCount_q + 6'h01;
      end else if (pop && !push) begin
        fifoCount_q <= fifoCount_q - 6'h01;
      end
      // Results arriving on a full FIFO are dropped; the flag says so
      if (convDone && fifoFull) begin
        overflow_q <= 1'b1;
      end
      irq_q <= (threshold != 6'h00) && (fifoCount_q >= threshold);
    end
  end

  assign resultIrq = irq_q;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Read data

  wire [31:0] instrRd  = {16'h0000, ram_q[BANK_INSTR][wordIdx]};
  wire [31:0] bankRd   = (ramPtr_q == BANK_HIGH) ? {16'h0000, ram_q[BANK_HIGH][wordIdx]} :
                         (ramPtr_q == BANK_LOW)  ? {16'h0000, ram_q[BANK_LOW][wordIdx]}  :
                         (ramPtr_q == BANK_INSTR) ? instrRd : 32'h00000000;
  wire [31:0] cfgRd    = {22'h000000, ramPtr_q, 4'h0, calPending_q, 2'b00, running_q};
  wire [31:0] fifoRd   = fifoEmpty ? 32'h00000000 : {16'h0000, fifoMem[rdPtr_q]};
  wire [31:0] statusRd = {16'h0000, overflow_q, irq_q, 3'h0, instrPtr_q,
                          state_q, 1'b0, fifoEmpty, fifoFull, running_q};
  wire [31:0] countRd  = {26'h0000000, fifoCount_q};
  wire [31:0] rdMux    = selInstr  ? bankRd :
                         selConfig ? cfgRd :
                         selTimer  ? {16'h0000, timerPreset_q} :
                         selFifo   ? fifoRd :
                         selStatus ? (statusRd | {countRd[15:0], 16'h0000}) :
                         selCtrl   ? {16'h0000, control_q} :
                         selLimit  ? {16'h0000, lowFlags_q, highFlags_q} : 32'h00000000;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata_q <= 32'h00000000;
    end else if (rdStrobe) begin
      hrdata_q <= rdMux;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  read_wait_a: assert property (
    addrPhase && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");

  pause_access_a: assert property (
    dpValid_q && !dpWrite_q |=> $stable(state_q) && $stable(cnt_q))
    else $error("sequencer advanced during a host access");

  conv_length_a: assert property (
    $changed(state_q) && state_q == S_CONV |->
      cnt_q == (cur.res8 ? LEN_CONV8 : LEN_CONV12) - LEN_SINGLE)
    else $error("conversion state loaded wrong length");

  cmp_phases_a: assert property (
    $changed(state_q) && state_q == S_CMPA |-> cnt_q == LEN_CMP_LONG - LEN_SINGLE)
    else $error("compare phase loaded wrong length");

  timer_load_a: assert property (
    $changed(state_q) && state_q == S_TIMER |->
      cnt_q == CNT_W'({timerPreset_q, 5'b0}) + LEN_TMR_FIXED - LEN_SINGLE)
    else $error("timer delay loaded wrong count");

  loop_back_a: assert property (
    instrEnd && cur.loop && running_q && !softReset |=> instrPtr_q == 3'h0)
    else $error("loop bit did not return to instruction zero");

  next_instr_a: assert property (
    instrEnd && !cur.loop && running_q && !softReset |=>
      instrPtr_q == 3'($past(instrPtr_q) + 3'h1) && state_q == S_FETCH)
    else $error("next instruction not started at once");

  timer_first_a: assert property (
    stepNow && state_q == S_DECODE && cur.timerEn && running_q && !softReset |=>
      state_q == S_TIMER)
    else $error("timer delay skipped");

  start_cmd_a: assert property (
    cfgWrite && hwdata[CFG_START] && !hwdata[CFG_RESET] |=> running_q)
    else $error("start command did not start the sequencer");

  irq_level_a: assert property (
    threshold != 6'h00 && fifoCount_q >= threshold && !softReset |=> resultIrq)
    else $error("threshold reached without interrupt");

endmodule : das_instruction_sequencer

// file: core/das_seq_pkg.sv
// Shared constants, field layouts and types of the acquisition-system instruction sequencer
package das_seq_pkg;

  localparam int unsigned INSTR_WORDS = 8;
  localparam int unsigned RAM_BANKS   = 3;
  localparam int unsigned FIFO_DEPTH  = 32;
  localparam int unsigned CNT_W       = 22;

  // Register byte offsets (word aligned, low byte of haddr)
  localparam logic [7:0] OFS_INSTR0  = 8'h00;
  localparam logic [7:0] OFS_CONFIG  = 8'h20;
  localparam logic [7:0] OFS_TIMER   = 8'h24;
  localparam logic [7:0] OFS_FIFO    = 8'h28;
  localparam logic [7:0] OFS_STATUS  = 8'h2c;
  localparam logic [7:0] OFS_CONTROL = 8'h30;
  localparam logic [7:0] OFS_LIMIT   = 8'h34;

  // Configuration register fields
  localparam int unsigned CFG_START   = 0;
  localparam int unsigned CFG_RESET   = 1;
  localparam int unsigned CFG_FULLCAL = 3;
  localparam int unsigned CFG_RPTR_LO = 8;
  localparam int unsigned CFG_RPTR_HI = 9;

  // Control register fields
  localparam int unsigned CTL_THR_LO = 0;
  localparam int unsigned CTL_THR_HI = 5;
  localparam int unsigned CTL_TAG    = 8;

  localparam logic [1:0]  BANK_INSTR = 2'h0;
  localparam logic [1:0]  BANK_HIGH  = 2'h1;
  localparam logic [1:0]  BANK_LOW   = 2'h2;
  localparam logic [2:0]  NEG_GROUND = 3'h0;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;

  // Sequencer timing, in converter clocks
  localparam logic [CNT_W-1:0] LEN_SINGLE     = 22'h000001;
  localparam logic [CNT_W-1:0] LEN_CONV12     = 22'h00002c; // 44
  localparam logic [CNT_W-1:0] LEN_CONV8      = 22'h000015; // 21
  localparam logic [CNT_W-1:0] LEN_CMP_LONG   = 22'h000005;
  localparam logic [CNT_W-1:0] LEN_CMP_SHORT  = 22'h000001;
  localparam logic [CNT_W-1:0] LEN_ACQ12      = 22'h000009;
  localparam logic [CNT_W-1:0] LEN_ACQ8       = 22'h000002;
  localparam logic [CNT_W-1:0] LEN_TMR_FIXED  = 22'h000002;
  localparam logic [CNT_W-1:0] LEN_CAL        = 22'h0003e8;
  localparam int unsigned      TMR_SHIFT      = 5;          // 32 clocks per count

  localparam logic [15:0] RST_TIMER   = 16'h0000;
  localparam logic [15:0] RST_CONTROL = 16'h0000;

  typedef struct packed {
    logic [3:0] acqTime;
    logic       wdog;
    logic       res8;
    logic       timerEn;
    logic       syncEn;
    logic [2:0] negSel;
    logic [2:0] posSel;
    logic       pauseEn;
    logic       loop;
  } instr_t;

  typedef enum logic [3:0] {
    S_IDLE   = 4'b0000,
    S_FETCH  = 4'b0001,
    S_DECODE = 4'b0010,
    S_TIMER  = 4'b0011,
    S_ACQ    = 4'b0100,
    S_CONV   = 4'b0101,
    S_CMPA   = 4'b0110,
    S_CMPB   = 4'b0111,
    S_CMPC   = 4'b1000,
    S_CAL    = 4'b1001
  } seq_state_t;

  typedef struct packed {
    logic [2:0] posSel;
    logic [2:0] negSel;
    logic       singleEnded;
    logic       res8;
    logic       acquire;
    logic       convert;
    logic       compare;
    logic       calibrate;
  } afe_ctrl_t;

endpackage : das_seq_pkg

// file: testbench/afe_partner.sv
// Converter model that answers with its own input selection
`timescale 1ns/10ps
module afe_partner
  import das_seq_pkg::*;
(
  input  wire das_seq_pkg::afe_ctrl_t afeCtrl,  // Front-end control
  output logic [12:0]                 convData  // Result to the sequencer
);
  wire [12:0] sel = {7'h0, afeCtrl.negSel, afeCtrl.posSel};
  // Outside a conversion or compare the line changes, so a stale sample cannot pass
  assign convData = (afeCtrl.convert | afeCtrl.compare) ? sel : ~sel;
endmodule : afe_partner

// file: testbench/tb.sv
// Self-checking bench of the instruction sequencer
`timescale 1ns/10ps
module tb;
  import das_seq_pkg::*;
  logic        core_clk, arst_n, hsel, hwrite, hreadyout, hresp, resultIrq, rdyS, irqS;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, hrS, rd, d;
  logic [12:0] convData;
  afe_ctrl_t   afeCtrl, afeS;
  int          num_errors, n_compared, n, t0, lead, len;
  localparam logic [15:0] TW [4] = '{16'h0401, 16'h0601, 16'h2401, 16'h0001};
  localparam int          TX [4] = '{0, 34, 4, 7};
  localparam int          TL [4] = '{21, 21, 21, 44};
  localparam logic [15:0] PRG [3] = '{16'h0400, 16'h0428, 16'h0405};
  localparam logic [5:0]  SEL [3] = '{6'h00, 6'h0a, 6'h01};

  das_instruction_sequencer dut (.core_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .convData, .afeCtrl, .resultIrq);
  afe_partner afe (.afeCtrl, .convData);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Copies taken mid-cycle keep bench decisions clear of edge races
  always @(negedge core_clk) begin
    rdyS <= hreadyout;
    hrS  <= hrdata;
    irqS <= resultIrq;
    afeS <= afeCtrl;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (rdyS !== 1'b1 && k < 50);
    if (k >= 50) begin
      num_errors++;
      report_and_stop();
    end
  endtask : wait_rdy

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrS;
  endtask : xfer

  task automatic run_conv;
    lead = 0;
    len = 0;
    while (afeS.convert !== 1'b1 && lead < 2000) begin
      @(posedge core_clk);
      lead++;
    end
    while (afeS.convert === 1'b1 && len < 100) begin
      @(posedge core_clk);
      len++;
    end
  endtask : run_conv
  //////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h31f098e2));
    {arst_n, hsel, htrans, hwrite, haddr, hwdata} = '0;
    hsize = HSIZE_WORD;
    num_errors = 0;
    n_compared = 0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    xfer(1'b0, OFS_TIMER, 32'h0);
    check("timer", rd, {16'h0, RST_TIMER});
    xfer(1'b0, OFS_CONTROL, 32'h0);
    check("control", rd, {16'h0, RST_CONTROL});
    xfer(1'b0, 8'h3c, 32'h0);
    check("unmapped", rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = $urandom();
      xfer(1'b1, 8'(4 * i), d);
      xfer(1'b0, 8'(4 * i), 32'h0);
      check("instr word", rd, {16'h0, d[15:0]});
    end
    // Lead times are compared to the first entry, so bus overhead cancels
    xfer(1'b1, OFS_TIMER, 32'h1);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, OFS_INSTR0, {16'h0, TW[i]});
      xfer(1'b1, OFS_CONFIG, 32'h1);
      run_conv();
      if (i == 0) t0 = lead;
      check("lead", lead - t0, TX[i]);
      check("conv length", len, TL[i]);
      xfer(1'b1, OFS_CONFIG, 32'h0);
    end
    xfer(1'b0, OFS_STATUS, 32'h0);
    check("stopped", rd & 32'h1, 32'h0);
    // Timing runs left results behind; a soft reset empties the FIFO first
    xfer(1'b1, OFS_CONFIG, 32'h2);
    for (int i = 0; i < 3; i++) xfer(1'b1, 8'(4 * i), {16'h0, PRG[i]});
    xfer(1'b1, OFS_CONTROL, 32'h106);
    xfer(1'b1, OFS_CONFIG, 32'h1);
    n = 0;
    while (irqS !== 1'b1 && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    check("irq", irqS, 32'h1);
    // Read out while the loop keeps converting
    for (int k = 0; k < 6; k++) begin
      xfer(1'b0, OFS_FIFO, 32'h0);
      d = {16'h0, 3'(k % 3), 7'h0, SEL[k % 3]};
      check("result", rd, d);
    end
    xfer(1'b1, OFS_CONFIG, 32'h2);
    xfer(1'b0, OFS_STATUS, 32'h0);
    check("soft reset", rd & 32'h4005, 32'h4);
    xfer(1'b1, OFS_CONFIG, 32'h100);
    xfer(1'b1, OFS_INSTR0, 32'h1234);
    xfer(1'b0, OFS_STATUS, 32'h0);
    check("bank1 stopped", rd & 32'h1, 32'h0);
    xfer(1'b1, OFS_CONFIG, 32'h0);
    xfer(1'b0, OFS_INSTR0, 32'h0);
    check("bank0", rd, 32'h400);
    xfer(1'b1, OFS_CONFIG, 32'h100);
    xfer(1'b0, OFS_INSTR0, 32'h0);
    check("bank1", rd, 32'h1234);
    // Watchdog loop on input zero: high limit 0x1234 is negative, low limit zero
    xfer(1'b1, OFS_CONFIG, 32'h0);
    xfer(1'b1, OFS_INSTR0, 32'h0801);
    xfer(1'b1, OFS_CONFIG, 32'h1);
    repeat (40) @(posedge core_clk);
    xfer(1'b1, OFS_CONFIG, 32'h0);
    xfer(1'b0, OFS_LIMIT, 32'h0);
    check("limit flags", rd, 32'h1);
    xfer(1'b0, OFS_LIMIT, 32'h0);
    check("limit cleared", rd, 32'h0);
    xfer(1'b0, OFS_STATUS, 32'h0);
    check("no compare result", rd & 32'h4, 32'h4);
    xfer(1'b1, OFS_CONFIG, 32'h8);
    n = 0;
    while (afeS.calibrate !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    check("calibrate", afeS.calibrate, 32'h1);
    report_and_stop();
  end
endmodule : tb
